// ---- logic/smc_supply_monitor_control.sv ----
// Supply monitor control: threshold selection, comparator status and detector duty cycling.
`timescale 1ns/1ps
//
// Contract
// - Reset level bits 5:4 choose reset threshold.
// - Level 11 suppresses reset, status uses 3V.
// - Trip bits 2:0 choose low-voltage threshold.
// - Trip field also sets flash enable level.
// - Status bit 1 shows low-voltage comparator.
// - Status bit 0 shows precision reset comparator.
// - Status read-only; bits 7:2 read zero.
// - Trim bits 7:6 set detector duty periods.
// - Sleep runs detectors duty-cycled, longer latency.
module smc_supply_monitor_control
    import smc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [8:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic i_io_rd,
    input wire logic [7:0] i_io_wdata,
    input wire logic i_ext_bank_select,
    output logic [7:0] o_io_rdata,
    input wire logic i_sleep,
    input wire logic i_lowspeed_clk,
    input wire logic i_lowv_cmp,
    input wire logic i_precise_cmp,
    output logic [1:0] o_precise_reset_level,
    output logic o_precise_sel_30,
    output logic [2:0] o_lowv_trip_select,
    output logic o_lowv_trip_reserved,
    output logic o_flash_level_select_valid,
    output logic o_precise_reset,
    output logic o_detector_enable
);
    logic [7:0] ctrl;
    logic [7:0] trim;
    logic [1:0] status;
    logic [SMC_DUTY_W-1:0] duty_count;
    logic lsclk_prev;
    smc_det_e det_state;
    logic [7:0] rdata;
    logic [7:0] next_ctrl;
    logic [7:0] next_trim;
    logic [1:0] next_status;
    logic [SMC_DUTY_W-1:0] next_duty_count;
    logic next_lsclk_prev;
    smc_det_e next_det_state;
    logic [7:0] next_rdata;
    logic [2:0] sync_out;
    logic lsclk_s;
    logic lowv_s;
    logic precise_s;
    logic lsclk_rise;
    logic [SMC_DUTY_W-1:0] duty_len;
    logic [1:0] level;
    logic bank_ok;

    ////////////////////////////////////////////////////////////////////////
    // Pins and the slow clock come from outside this domain.
    // The slow clock is sampled as data; its edges arrive two cycles late, far below its period.
    smc_sync #(
        .WIDTH(3)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_async({i_lowspeed_clk, i_lowv_cmp, i_precise_cmp}),
        .o_sync(sync_out)
    );

    assign lsclk_s = sync_out[2];
    assign lowv_s = sync_out[1];
    assign precise_s = sync_out[0];
    assign lsclk_rise = lsclk_s & ~lsclk_prev;
    assign level = ctrl[SMC_LEVEL_LSB +: 2];
    // Registers respond only while the extended bank is selected.
    // bank gated decode
    assign bank_ok = i_ext_bank_select;

    ////////////////////////////////////////////////////////////////////////
    // Duty window length from the trim field.
    always_comb begin
        case (trim[SMC_DUTY_LSB +: 2])
            2'h0: duty_len = SMC_DUTY_P0;
            2'h1: duty_len = SMC_DUTY_P1;
            2'h2: duty_len = SMC_DUTY_P2;
            2'h3: duty_len = SMC_DUTY_P3;
            default: duty_len = SMC_DUTY_P0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes; reserved bits are masked so they always read zero.
    always_comb begin
        next_ctrl = ctrl;
        next_trim = trim;
        if (i_io_wr && bank_ok && i_io_addr == SMC_CTRL_OFFSET) begin
            next_ctrl = i_io_wdata & SMC_CTRL_MASK;
        end
        if (i_io_wr && bank_ok && i_io_addr == SMC_TRIM_OFFSET) begin
            next_trim = i_io_wdata & SMC_TRIM_MASK;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            ctrl <= SMC_CTRL_RESET;
            trim <= SMC_TRIM_RESET;
        end else begin
            ctrl <= next_ctrl;
            trim <= next_trim;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Detector duty cycling. Awake, the detectors stay on; asleep, they
    // alternate on and off windows, trading latency for supply current.
    always_comb begin
        next_det_state = det_state;
        next_duty_count = duty_count;
        next_lsclk_prev = lsclk_s;
        if (!i_sleep) begin
            next_det_state = SMC_DET_ON;
            next_duty_count = '0;
        end else if (lsclk_rise) begin
            // A shorter duty code written mid-window must still end the window,
            // so the compare is at-or-above rather than equal.
            if (duty_count >= duty_len - 10'h001) begin
                next_duty_count = '0;
                case (det_state)
                    SMC_DET_ON: next_det_state = SMC_DET_OFF;
                    SMC_DET_OFF: next_det_state = SMC_DET_ON;
                    default: next_det_state = SMC_DET_ON;
                endcase
            end else begin
                next_duty_count = duty_count + 10'h001;
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            det_state <= SMC_DET_ON;
            duty_count <= '0;
            lsclk_prev <= 1'b0;
        end else begin
            det_state <= next_det_state;
            duty_count <= next_duty_count;
            lsclk_prev <= next_lsclk_prev;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparator status, sampled only while the detectors are powered.
    always_comb begin
        // Status is a pure sample with no sticky bits; software sees the level last sampled while the detectors were on.
        next_status = status;
        if (det_state == SMC_DET_ON) begin
            next_status[SMC_LOWV_BIT] = lowv_s;
            next_status[SMC_PREC_BIT] = precise_s;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            status <= SMC_STATUS_RESET;
        end else begin
            status <= next_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, registered; unmapped or out-of-bank reads return zero.
    always_comb begin
        next_rdata = 8'h00;
        if (i_io_rd && bank_ok) begin
            case (i_io_addr)
                SMC_CTRL_OFFSET: next_rdata = ctrl;
                SMC_STATUS_OFFSET: next_rdata = {6'h00, status};
                SMC_TRIM_OFFSET: next_rdata = trim;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign o_io_rdata = rdata;

    ////////////////////////////////////////////////////////////////////////
    // Analog trim outputs follow the control register directly; the reset output also needs the status bit.
    // reset threshold select
    assign o_precise_reset_level = level;
    assign o_precise_sel_30 = (level == SMC_LEVEL_30) || (level == SMC_LEVEL_NORST);
    // Reserved level code behaves as the 2.7 V range; software must avoid it.
    // reset suppressed at level 11
    assign o_precise_reset = status[SMC_PREC_BIT] && (level != SMC_LEVEL_NORST);
    assign o_lowv_trip_select = ctrl[SMC_TRIP_LSB +: 3];
    assign o_lowv_trip_reserved = ctrl[SMC_TRIP_LSB +: 3] > SMC_TRIP_MAX;
    assign o_flash_level_select_valid = ~o_lowv_trip_reserved;
    // Detector power comes straight from the state register, so it cannot glitch.
    // detector power gate
    assign o_detector_enable = (det_state == SMC_DET_ON);
endmodule

// ---- logic/smc_pkg.sv ----
// Package holding register map, field layout and timing constants of the supply monitor control block.
package smc_pkg;
    // Register offsets in the second I/O bank.
    localparam logic [8:0] SMC_CTRL_OFFSET = 9'h1e3;
    localparam logic [8:0] SMC_STATUS_OFFSET = 9'h1e4;
    localparam logic [8:0] SMC_TRIM_OFFSET = 9'h1eb;
    // Reset values.
    localparam logic [7:0] SMC_CTRL_RESET = 8'h00;
    localparam logic [7:0] SMC_TRIM_RESET = 8'h00;
    localparam logic [1:0] SMC_STATUS_RESET = 2'h0;
    // Field positions.
    localparam int SMC_LEVEL_LSB = 4;
    localparam int SMC_TRIP_LSB = 0;
    localparam int SMC_DUTY_LSB = 6;
    localparam int SMC_LOWV_BIT = 1;
    localparam int SMC_PREC_BIT = 0;
    // Writable bit masks; all other bits are reserved and read as zero.
    localparam logic [7:0] SMC_CTRL_MASK = 8'h37;
    localparam logic [7:0] SMC_TRIM_MASK = 8'hc0;
    // Reset level codes.
    localparam logic [1:0] SMC_LEVEL_27 = 2'h0;
    localparam logic [1:0] SMC_LEVEL_30 = 2'h1;
    localparam logic [1:0] SMC_LEVEL_RSVD = 2'h2;
    localparam logic [1:0] SMC_LEVEL_NORST = 2'h3;
    // Trip select codes; 3'h4 and above are reserved.
    localparam logic [2:0] SMC_TRIP_MAX = 3'h3;
    // Duty cycle window lengths in low-speed clock periods.
    localparam logic [9:0] SMC_DUTY_P0 = 10'h080;
    localparam logic [9:0] SMC_DUTY_P1 = 10'h200;
    localparam logic [9:0] SMC_DUTY_P2 = 10'h020;
    localparam logic [9:0] SMC_DUTY_P3 = 10'h008;
    localparam int SMC_DUTY_W = 10;
    // Detector duty states, one-hot.
    typedef enum logic [1:0] {
        SMC_DET_ON = 2'b01,
        SMC_DET_OFF = 2'b10
    } smc_det_e;
endpackage

// ---- logic/smc_sync.sv ----
// Two flip-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
module smc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_stage2;

    ////////////////////////////////////////////////////////////////////////
    // The first stage feeds only the second, so metastability cannot reach logic.
    always_comb begin
        next_stage1 = i_async;
        next_stage2 = stage1;
    end

    // Registered stages.
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign o_sync = stage2;
endmodule

// ---- tb/smc_supply_monitor_control_props.sv ----
// Checker of port relations of the supply monitor control block.
`timescale 1ns/1ps
module smc_props (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [8:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic i_io_rd,
    input wire logic [7:0] i_io_wdata,
    input wire logic i_ext_bank_select,
    input wire logic [7:0] o_io_rdata,
    input wire logic i_sleep,
    input wire logic [1:0] o_precise_reset_level,
    input wire logic o_precise_sel_30,
    input wire logic [2:0] o_lowv_trip_select,
    input wire logic o_lowv_trip_reserved,
    input wire logic o_flash_level_select_valid,
    input wire logic o_precise_reset,
    input wire logic o_detector_enable
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    ////////////////////////////////////////////////////////////////
    // Bus relations; a read outside the bank must never leak register data.
    property p_rd_idle;
        !(i_io_rd && i_ext_bank_select) |=> o_io_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_status_hi;
        i_io_rd && i_ext_bank_select && i_io_addr == 9'h1e4 |=> o_io_rdata[7:2] == 6'h00;
    endproperty
    a_status_hi: assert property (p_status_hi) else $error("status upper bits set");
    property p_ctrl_wr;
        i_io_wr && i_ext_bank_select && i_io_addr == 9'h1e3 |=>
            {2'b00, o_precise_reset_level, 1'b0, o_lowv_trip_select} == ($past(i_io_wdata) & 8'h37);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");
    property p_ctrl_hold;
        !(i_io_wr && i_ext_bank_select && i_io_addr == 9'h1e3) |=> $stable(o_lowv_trip_select);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("trip select moved");
    ////////////////////////////////////////////////////////////////
    // Decodes of the control fields.
    property p_sel30;
        o_precise_sel_30 == o_precise_reset_level[0];
    endproperty
    a_sel30: assert property (p_sel30) else $error("range decode wrong");
    property p_norst;
        o_precise_reset_level == 2'h3 |-> !o_precise_reset;
    endproperty
    a_norst: assert property (p_norst) else $error("reset while suppressed");
    property p_rsvd;
        o_lowv_trip_reserved == o_lowv_trip_select[2];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved trip decode wrong");
    property p_flash;
        o_flash_level_select_valid != o_lowv_trip_reserved;
    endproperty
    a_flash: assert property (p_flash) else $error("flash level decode wrong");
    // Awake the detectors never duty cycle.
    property p_awake;
        (!i_sleep) [*3] |-> o_detector_enable;
    endproperty
    a_awake: assert property (p_awake) else $error("detector off while awake");
endmodule
bind smc_supply_monitor_control smc_props smc_props_inst (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata),
    .i_ext_bank_select(i_ext_bank_select), .o_io_rdata(o_io_rdata), .i_sleep(i_sleep),
    .o_precise_reset_level(o_precise_reset_level), .o_precise_sel_30(o_precise_sel_30),
    .o_lowv_trip_select(o_lowv_trip_select), .o_lowv_trip_reserved(o_lowv_trip_reserved),
    .o_flash_level_select_valid(o_flash_level_select_valid), .o_precise_reset(o_precise_reset),
    .o_detector_enable(o_detector_enable));

// ---- tb/test_supply_monitor_control.sv ----
// Self-checking bench of the supply monitor control block.
`timescale 1ns/1ps
module test_supply_monitor_control;
    import smc_pkg::*;
    logic i_mclk = 0, i_reset = 1, i_io_wr = 0, i_io_rd = 0, i_ext_bank_select = 1;
    logic i_sleep = 0, i_lowspeed_clk = 0, i_lowv_cmp = 0, i_precise_cmp = 0;
    logic [8:0] i_io_addr = 9'h000;
    logic [7:0] i_io_wdata = 8'h00, o_io_rdata, d;
    logic [1:0] o_precise_reset_level;
    logic [2:0] o_lowv_trip_select;
    logic o_precise_sel_30, o_lowv_trip_reserved, o_flash_level_select_valid, o_precise_reset, o_detector_enable;
    int error_cnt = 0, n_compared = 0, seed = 11;
    always #2 i_mclk = ~i_mclk;
    smc_supply_monitor_control smc_supply_monitor_control_inst (.i_mclk, .i_reset, .i_io_addr, .i_io_wr,
        .i_io_rd, .i_io_wdata, .i_ext_bank_select, .o_io_rdata, .i_sleep, .i_lowspeed_clk, .i_lowv_cmp,
        .i_precise_cmp, .o_precise_reset_level, .o_precise_sel_30, .o_lowv_trip_select, .o_lowv_trip_reserved,
        .o_flash_level_select_valid, .o_precise_reset, .o_detector_enable);
    ////////////////////////////////////////////////////////////////
    // Expectation helpers built from the field layout.
    function automatic logic [7:0] stat_exp(input logic l, input logic p);
        return {6'h00, l, p};
    endfunction
    function automatic int duty(input logic [1:0] c);
        return (c == 2'h0) ? 128 : (c == 2'h1) ? 512 : (c == 2'h2) ? 32 : 8;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Strobes last one cycle, so each access takes two falling edges.
    task automatic wr(input logic [8:0] a, input logic [7:0] v);
        @(negedge i_mclk);
        i_io_addr = a;
        i_io_wdata = v;
        i_io_wr = 1'b1;
        @(negedge i_mclk);
        i_io_wr = 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        @(negedge i_mclk);
        i_io_addr = a;
        i_io_rd = 1'b1;
        @(negedge i_mclk);
        i_io_rd = 1'b0;
        check(o_io_rdata, exp);
    endtask
    // The slow clock is far slower than the bus clock; seven cycles a period keeps runs short.
    task automatic slow(input int n);
        repeat (n) begin
            @(negedge i_mclk);
            i_lowspeed_clk = 1'b1;
            repeat (3) @(negedge i_mclk);
            i_lowspeed_clk = 1'b0;
            repeat (3) @(negedge i_mclk);
        end
    endtask
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // A hang counts as a mismatch.
    initial begin
        repeat (20000) @(posedge i_mclk);
        error_cnt++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge i_mclk);
        i_reset = 1'b0;
        rd(SMC_CTRL_OFFSET, 8'h00);
        rd(SMC_STATUS_OFFSET, 8'h00);
        rd(SMC_TRIM_OFFSET, 8'h00);
        $display("Reset values done");
        // Random control values, all ones and the suppressed level first.
        for (int k = 0; k < 12; k++) begin
            d = (k == 0) ? 8'hff : (k == 1) ? 8'h30 : 8'($random(seed));
            wr(SMC_CTRL_OFFSET, d);
            check({7'h00, o_lowv_trip_reserved}, {7'h00, d[2]});
            check({7'h00, o_flash_level_select_valid}, {7'h00, ~d[2]});
            check({6'h00, o_precise_reset_level}, {6'h00, d[5:4]});
            check({7'h00, o_precise_sel_30}, {7'h00, d[4]});
            check({5'h00, o_lowv_trip_select}, {5'h00, d[2:0]});
            rd(SMC_CTRL_OFFSET, d & 8'h37);
        end
        // Refused accesses: bank off, status write, unmapped read.
        i_ext_bank_select = 1'b0;
        wr(SMC_CTRL_OFFSET, 8'h21);
        rd(SMC_CTRL_OFFSET, 8'h00);
        i_ext_bank_select = 1'b1;
        rd(SMC_CTRL_OFFSET, d & 8'h37);
        wr(SMC_STATUS_OFFSET, 8'hff);
        rd(SMC_STATUS_OFFSET, 8'h00);
        rd(9'h1e5, 8'h00);
        $display("Control register done");
        // Every comparator pair under normal and suppressed reset level.
        for (int k = 0; k < 8; k++) begin
            wr(SMC_CTRL_OFFSET, k[2] ? 8'h30 : 8'h00);
            i_lowv_cmp = k[1];
            i_precise_cmp = k[0];
            repeat (4) @(negedge i_mclk);
            rd(SMC_STATUS_OFFSET, stat_exp(k[1], k[0]));
            check({7'h00, o_precise_reset}, {7'h00, k[0] & ~k[2]});
            check({7'h00, o_precise_sel_30}, {7'h00, k[2]});
        end
        $display("Comparator status done");
        // Each duty code: window length exact, status frozen while off.
        for (int c = 0; c < 4; c++) begin
            wr(SMC_TRIM_OFFSET, {c[1:0], 6'h3f});
            rd(SMC_TRIM_OFFSET, {c[1:0], 6'h00});
            i_sleep = 1'b1;
            slow(duty(c[1:0]) - 1);
            check({7'h00, o_detector_enable}, 8'h01);
            slow(1);
            check({7'h00, o_detector_enable}, 8'h00);
            i_lowv_cmp = ~i_lowv_cmp;
            repeat (6) @(negedge i_mclk);
            rd(SMC_STATUS_OFFSET, stat_exp(~i_lowv_cmp, i_precise_cmp));
            i_sleep = 1'b0;
            repeat (6) @(negedge i_mclk);
            check({7'h00, o_detector_enable}, 8'h01);
            rd(SMC_STATUS_OFFSET, stat_exp(i_lowv_cmp, i_precise_cmp));
        end
        $display("Duty cycling done");
        close_out();
    end
endmodule
